// ==== design/pmusb_regbank.v ====
`timescale 1ns/1ns
`include "pmusb_regs.vh"

module pmusb_regbank (
    // clock and power-loss reset
    input  wire       clk,
    input  wire       arst_n,
    // register access port
    input  wire       regWrite,
    input  wire       regRead,
    input  wire [7:0] regAddr,
    input  wire [7:0] regWdata,
    output reg  [7:0] regRdata,
    output reg        regRvalid,
    // analog status and pins
    input  wire       monitorBelow,
    input  wire       outputGood,
    input  wire       regulatorFault,
    input  wire       voltageSelectPin,
    input  wire       hibernateActive,
    input  wire       systemShutdown,
    // regulator and system controls
    output reg        regulatorEnable,
    output reg  [5:0] regulatorVoltageCode,
    output reg        regulatorPhaseShift,
    output reg        regulatorForcePwm,
    output reg  [2:0] regulatorDelay,
    output reg        resetTimeoutLong,
    output reg        monitorIrq,
    output reg        faultIrq,
    output reg        shutdownRequest
);

    // ==========================================================
    // register storage
    reg  [7:0] sysMon;
    reg  [7:0] hibScr;
    reg  [7:0] voltPri;
    reg  [7:0] voltSec;
    reg  [7:0] ctrl;

    // ==========================================================
    // next values
    reg  [7:0] next_sysMon;
    reg  [7:0] next_hibScr;
    reg  [7:0] next_voltPri;
    reg  [7:0] next_voltSec;
    reg  [7:0] next_ctrl;
    reg  [7:0] next_rdata;
    reg        next_enable;
    reg  [5:0] next_code;
    reg        next_monitorIrq;
    reg        next_shutdown;
    reg        next_faultIrq;

    // ==========================================================
    // address decode
    localparam NUM_REGS = 5;
    localparam IDX_SYS  = 0;
    localparam IDX_HIB  = 1;
    localparam IDX_PRI  = 2;
    localparam IDX_SEC  = 3;
    localparam IDX_CTL  = 4;

    wire [NUM_REGS-1:0] addrHit;
    wire [NUM_REGS-1:0] writeHit;

    function hit;
        input [7:0] a;
        input [7:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    // slot to byte offset; any slot past the map lands on control
    function [7:0] offsetOf;
        input integer idx;
        begin
            if (idx == IDX_SYS) begin
                offsetOf = `PMUSB_OFS_SYSMON;
            end else if (idx == IDX_HIB) begin
                offsetOf = `PMUSB_OFS_HIBSCR;
            end else if (idx == IDX_PRI) begin
                offsetOf = `PMUSB_OFS_B1VPRI;
            end else if (idx == IDX_SEC) begin
                offsetOf = `PMUSB_OFS_B1VSEC;
            end else begin
                offsetOf = `PMUSB_OFS_B1CTRL;
            end
        end
    endfunction

    // one comparator per mapped byte, shared by read and write
    genvar k;
    generate
        for (k = 0; k < NUM_REGS; k = k + 1) begin : g_dec
            assign addrHit[k]  = hit(regAddr, offsetOf(k));
            assign writeHit[k] = regWrite & addrHit[k];
        end
    endgenerate

    // ==========================================================
    // next register values
    always @* begin
        next_sysMon = sysMon;
        if (writeHit[IDX_SYS]) begin
            // status bit is never stored, it is read live
            next_sysMon = regWdata & `PMUSB_WM_SYSMON;
        end
    end

    // shutdown beats a same-cycle write; ready and force-on survive
    always @* begin
        next_hibScr = hibScr;
        if (systemShutdown) begin
            next_hibScr = hibScr & ~`PMUSB_SCRATCH_MASK;
        end else if (writeHit[IDX_HIB]) begin
            next_hibScr = regWdata & `PMUSB_WM_HIBSCR;
        end
    end

    always @* begin
        next_voltPri = voltPri;
        if (writeHit[IDX_PRI]) begin
            next_voltPri = regWdata & `PMUSB_WM_VOLT;
        end
    end

    always @* begin
        next_voltSec = voltSec;
        if (writeHit[IDX_SEC]) begin
            next_voltSec = regWdata & `PMUSB_WM_VOLT;
        end
    end

    // power-good is live too, so bit 0 is never stored
    always @* begin
        next_ctrl = ctrl;
        if (writeHit[IDX_CTL]) begin
            next_ctrl = regWdata & `PMUSB_WM_B1CTRL;
        end
    end

    // ==========================================================
    // storage; async reset models loss of input power
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sysMon  <= `PMUSB_RST_SYSMON;
            hibScr  <= `PMUSB_RST_HIBSCR;
            voltPri <= `PMUSB_RST_B1VPRI;
            voltSec <= `PMUSB_RST_B1VSEC;
            ctrl    <= `PMUSB_RST_B1CTRL;
        end else begin
            sysMon  <= next_sysMon;
            hibScr  <= next_hibScr;
            voltPri <= next_voltPri;
            voltSec <= next_voltSec;
            ctrl    <= next_ctrl;
        end
    end

    // ==========================================================
    // named fields
    wire       fieldTrst;
    wire       fieldResp;
    wire       fieldIrqEn;
    wire       fieldForce;
    wire       fieldOn;
    wire       fieldPhase;
    wire       fieldPwm;
    wire [2:0] fieldDelay;
    wire       fieldFltEn;
    wire [5:0] codePri;
    wire [5:0] codeSec;

    assign fieldTrst  = sysMon[`PMUSB_SYS_TRST];
    assign fieldResp  = sysMon[`PMUSB_SYS_RESP];
    assign fieldIrqEn = sysMon[`PMUSB_SYS_IRQEN];
    assign fieldForce = hibScr[`PMUSB_HIB_FORCE];
    assign fieldOn    = ctrl[`PMUSB_CTL_ON];
    assign fieldPhase = ctrl[`PMUSB_CTL_PHASE];
    assign fieldPwm   = ctrl[`PMUSB_CTL_PWM];
    assign fieldDelay = ctrl[4:2];
    assign fieldFltEn = ctrl[`PMUSB_CTL_FLTEN];
    assign codePri    = voltPri[5:0];
    assign codeSec    = voltSec[5:0];

    // ==========================================================
    // read path; unmapped addresses read zero
    always @* begin
        next_rdata = 8'h00;
        if (addrHit[IDX_SYS]) begin
            next_rdata = sysMon;
            next_rdata[`PMUSB_SYS_BELOW] = monitorBelow;
        end else if (addrHit[IDX_HIB]) begin
            next_rdata = hibScr;
        end else if (addrHit[IDX_PRI]) begin
            next_rdata = voltPri;
        end else if (addrHit[IDX_SEC]) begin
            next_rdata = voltSec;
        end else if (addrHit[IDX_CTL]) begin
            next_rdata = ctrl;
            next_rdata[`PMUSB_CTL_PGOOD] = outputGood;
        end
    end

    // read data holds until the next read
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            regRdata <= next_rdata;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regRvalid <= 1'h0;
        end else begin
            regRvalid <= regRead;
        end
    end

    // ==========================================================
    // control decode
    always @* begin
        // force-on keeps the rail up only while hibernating
        next_enable = fieldOn |
            (hibernateActive & fieldForce);
    end

    always @* begin
        if (voltageSelectPin) begin
            next_code = codeSec;
        end else begin
            next_code = codePri;
        end
    end

    // levels, not sticky; the comparator holds the condition
    always @* begin
        next_monitorIrq = monitorBelow & fieldResp &
            fieldIrqEn;
        next_shutdown   = monitorBelow &
            ~fieldResp;
        next_faultIrq   = regulatorFault &
            fieldFltEn;
    end

    // ==========================================================
    // regulator outputs, one cycle behind the fields
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regulatorEnable <= 1'h0;
        end else begin
            regulatorEnable <= next_enable;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regulatorVoltageCode <= 6'h00;
        end else begin
            regulatorVoltageCode <= next_code;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regulatorPhaseShift <= 1'h0;
        end else begin
            regulatorPhaseShift <= fieldPhase;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regulatorForcePwm <= 1'h0;
        end else begin
            regulatorForcePwm <= fieldPwm;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regulatorDelay <= 3'h0;
        end else begin
            regulatorDelay <= fieldDelay;
        end
    end

    // ==========================================================
    // system outputs
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            resetTimeoutLong <= 1'h0;
        end else begin
            resetTimeoutLong <= fieldTrst;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            monitorIrq <= 1'h0;
        end else begin
            monitorIrq <= next_monitorIrq;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shutdownRequest <= 1'h0;
        end else begin
            shutdownRequest <= next_shutdown;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            faultIrq <= 1'h0;
        end else begin
            faultIrq <= next_faultIrq;
        end
    end

endmodule // pmusb_regbank

// ==== design/pmusb_regs.vh ====
`ifndef PMUSB_REGS_VH
`define PMUSB_REGS_VH
// ==========================================================
// register offsets
`define PMUSB_OFS_SYSMON    8'h00
`define PMUSB_OFS_HIBSCR    8'h01
`define PMUSB_OFS_B1VPRI    8'h20
`define PMUSB_OFS_B1VSEC    8'h21
`define PMUSB_OFS_B1CTRL    8'h22
// ==========================================================
// field positions
`define PMUSB_SYS_TRST      7
`define PMUSB_SYS_RESP      6
`define PMUSB_SYS_IRQEN     5
`define PMUSB_SYS_BELOW     4
`define PMUSB_HIB_FORCE     6
`define PMUSB_HIB_READY     1
`define PMUSB_CTL_ON        7
`define PMUSB_CTL_PHASE     6
`define PMUSB_CTL_PWM       5
`define PMUSB_CTL_FLTEN     1
`define PMUSB_CTL_PGOOD     0
// ==========================================================
// reset values and writable masks
`define PMUSB_RST_SYSMON    8'h00
`define PMUSB_RST_HIBSCR    8'h00
`define PMUSB_RST_B1VPRI    8'h00
`define PMUSB_RST_B1VSEC    8'h00
`define PMUSB_RST_B1CTRL    8'h00
`define PMUSB_WM_SYSMON     8'hEF
`define PMUSB_WM_HIBSCR     8'h4F
`define PMUSB_WM_VOLT       8'h3F
`define PMUSB_WM_B1CTRL     8'hFE
`define PMUSB_SCRATCH_MASK  8'h0D
`endif

// ==== test/pmusb_chk.sv ====
`timescale 1ns/1ns
// ====================
// register port and request checks
module pmusb_chk (
    // clock, reset, port
    input wire       clk,
    input wire       arst_n,
    input wire       regRead,
    input wire [7:0] regAddr,
    input wire [7:0] regRdata,
    // status and requests
    input wire       monitorBelow,
    input wire       regulatorFault,
    input wire       monitorIrq,
    input wire       faultIrq,
    input wire       shutdownRequest
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_fault_gate: assert property (faultIrq |-> $past(regulatorFault))
        else $error("fault irq without fault");
    a_irq_cause: assert property (monitorIrq |-> $past(monitorBelow))
        else $error("monitor irq without cause");
    a_shut_cause: assert property (shutdownRequest
        |-> $past(monitorBelow)) else $error("shutdown without cause");
    a_irq_or_shut: assert property (!(monitorIrq
        && shutdownRequest)) else $error("irq and shutdown together");
    a_unmapped_zero: assert property (regRead && !(regAddr inside
        {8'h00, 8'h01, 8'h20, 8'h21, 8'h22}) |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    a_volt_resv: assert property (regRead && regAddr[7:1] == 7'h10
        |=> regRdata[7:6] == 2'b00) else $error("voltage reserved set");
    a_hib_resv: assert property (regRead && regAddr == 8'h01
        |=> !regRdata[7] && regRdata[5:4] == 2'b00)
        else $error("hibernate reserved set");
    a_stat_live: assert property (regRead && regAddr == 8'h00
        |=> regRdata[4] == $past(monitorBelow)) else $error("status stale");
endmodule // pmusb_chk
bind pmusb_regbank pmusb_chk u_chk (.*);

// ==== test/pmusb_host.sv ====
`timescale 1ns/1ns
// =========================
// host on the register port
module pmusb_host (
    // port to the device
    input  wire       clk,
    output reg        regWrite,
    output reg        regRead,
    output reg  [7:0] regAddr,
    output reg  [7:0] regWdata
);
    initial {regWrite, regRead, regAddr, regWdata} = 18'h0FFFF;
    // idle bus shows inverted values so stale data cannot match
    task acc(input w, input [7:0] a, input [7:0] d);
        @(negedge clk);
        {regWrite, regRead, regAddr, regWdata} = {w, !w, a, d};
        @(negedge clk);
        {regWrite, regRead, regAddr, regWdata} = {2'b00, ~a, ~d};
    endtask
    // force-on up before hibernate, down after wake; ready flag kept
    task hib(input en);
        acc(1'b1, 8'h01, en ? 8'h42 : 8'h02);
    endtask
endmodule // pmusb_host

// ==== test/pmusb_regbank_tb_top.sv ====
`timescale 1ns/1ns
`include "pmusb_regs.vh"
module pmusb_regbank_tb_top;
    reg        clk = 1'b0;
    reg        arst_n = 1'b0;
    reg        monitorBelow = 1'b0, outputGood = 1'b0;
    reg        regulatorFault = 1'b0, voltageSelectPin = 1'b0;
    reg        hibernateActive = 1'b0, systemShutdown = 1'b0;
    wire       regWrite, regRead, regRvalid, regulatorEnable, faultIrq;
    wire       regulatorPhaseShift, regulatorForcePwm, resetTimeoutLong;
    wire       monitorIrq, shutdownRequest;
    wire [7:0] regAddr, regWdata, regRdata;
    wire [5:0] regulatorVoltageCode;
    wire [2:0] regulatorDelay;
    wire [15:0] outs = {regulatorEnable, regulatorPhaseShift,
        regulatorForcePwm, regulatorDelay, resetTimeoutLong, monitorIrq,
        faultIrq, shutdownRequest, regulatorVoltageCode};
    integer    n_errors = 0, tests_run = 0, i;
    reg  [7:0] q[$], d;
    reg  [7:0] ad [0:5] = '{8'h00, 8'h01, 8'h20, 8'h21, 8'h22, 8'h02};
    reg  [7:0] wm [0:4] = '{`PMUSB_WM_SYSMON, `PMUSB_WM_HIBSCR,
        `PMUSB_WM_VOLT, `PMUSB_WM_VOLT, `PMUSB_WM_B1CTRL};
    pmusb_regbank DUT (.*);
    pmusb_host host (.*);
    always #25 clk = ~clk;
    task cmp(input [63:0] nm, input [15:0] ex, input [15:0] gt);
        tests_run = tests_run + 1;
        if (ex !== gt) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0s exp %h got %h", nm, ex, gt);
        end
    endtask
    // outputs are registered one cycle behind their fields
    task cmpOut(input [63:0] nm, input [15:0] ex);
        repeat (2) @(negedge clk);
        cmp(nm, ex, outs);
    endtask
    task wr(input [7:0] a, input [7:0] v);
        host.acc(1'b1, a, v);
    endtask
    task rd(input [7:0] a, input [7:0] ex);
        q.push_back(ex);
        host.acc(1'b0, a, 8'h00);
    endtask
    always @(negedge clk)
        if (regRvalid === 1'b1) cmp("rdata", q.pop_front(), regRdata);
    task stop_test;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #100000 n_errors = n_errors + 1;
        stop_test;
    end
    initial begin
        void'($urandom(3));
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        cmpOut("reset", 16'h0000);
        for (i = 0; i < 6; i = i + 1) rd(ad[i], 8'h00);
        $display("reset test done");
        outputGood = 1'b1;
        for (i = 0; i < 5; i = i + 1) begin
            d = 8'($urandom);
            wr(ad[i], d);
            rd(ad[i], d & wm[i] | {7'h00, i == 4});
        end
        wr(8'h02, 8'hFF);
        rd(8'h02, 8'h00);
        $display("access test done");
        wr(8'h20, 8'h15);
        wr(8'h21, 8'h2A);
        wr(8'h22, 8'hE6);
        wr(8'h00, 8'h00);
        cmpOut("ctrl", 16'hE415);
        {voltageSelectPin, regulatorFault} = 2'b11;
        cmpOut("select", 16'hE4AA);
        wr(8'h22, 8'h04);
        cmpOut("off", 16'h042A);
        $display("regulator test done");
        monitorBelow = 1'b1;
        cmpOut("shut", 16'h046A);
        rd(8'h00, 8'h10);
        wr(8'h00, 8'hE5);
        cmpOut("irq", 16'h072A);
        rd(8'h00, 8'hF5);
        wr(8'h00, 8'hC5);
        cmpOut("irqoff", 16'h062A);
        monitorBelow = 1'b0;
        $display("monitor test done");
        host.hib(1'b1);
        wr(8'h01, 8'h4F);
        hibernateActive = 1'b1;
        cmpOut("hib", 16'h862A);
        systemShutdown = 1'b1;
        @(negedge clk) systemShutdown = 1'b0;
        rd(8'h01, 8'h42);
        hibernateActive = 1'b0;
        host.hib(1'b0);
        cmpOut("wake", 16'h062A);
        rd(8'h01, 8'h02);
        $display("hibernate test done");
        repeat (4) @(negedge clk);
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        cmpOut("rst2", 16'h0000);
        rd(8'h22, 8'h01);
        rd(8'h01, 8'h00);
        $display("reset again test done");
        repeat (4) @(negedge clk);
        stop_test;
    end
endmodule // pmusb_regbank_tb_top
